/* File: adcs_core.v */
// serial port, mode register, status flags and conversion sequencing
// assumes a front end that delivers a signed sample with range flags
// and a host on a three-wire port, serial clock idle high
//
// Notes on behaviour
// R1 - a new result written clears the ready flag
// R2 - ready sets after a result read and shortly before each update
// R3 - entering power-down sets the ready flag
// R4 - the data-out pin shows ready whenever no word is shifting
// R5 - error flag is written with ready, set when the result clamped
// R6 - a write that starts a conversion clears the error flag
// R7 - status bits five and four read zero, bit three reads one
// R8 - status bit two shows the fixed resolution variant
// R9 - two lowest status bits show the channel being converted
// R10 - eight-bit mode register, read and written with select value 01
// R11 - mode register resets to 0x02: continuous, bipolar
// R12 - mode byte travels most significant bit first
// R13 - any mode write resets modulator and filter, sets ready
// R14 - mode from bits seven and six, coding from bit two
// R15 - continuous mode converts back to back, ready low on each
// R16 - continuous read shifts each new result out without a command while chip select is low
// R17 - without continuous read the host commands each result read
// R18 - continuous: first result after two periods, then one each
// R19 - single mode: one result after two periods, then power-down
// R20 - single result and low ready held until read or next result
// R21 - mode field: 00 continuous, 01 reserved, 10 single, 11 off
// R22 - bit set gives straight binary, cleared gives offset binary
`timescale 1ns/1ps
`default_nettype none
`include "adcs_map.vh"

module adcs_core
#(
   parameter [`ADCS_CNT_W-1:0] P_RATE_CYCLES =
      `ADCS_T_ADC_US * `ADCS_CLK_MHZ,
   parameter [`ADCS_CNT_W-1:0] P_LEAD_CYCLES =
      `ADCS_LEAD_US * `ADCS_CLK_MHZ,
   // arbitrary value
   parameter [0:0]             P_RES_ID      = 1'b0
)
(
   input  wire                    i_core_clk,
   input  wire                    i_rst_n,
   input  wire                    i_cs_n,
   input  wire                    i_sclk,
   input  wire                    i_din,
   output reg                     o_dout,
   output reg                     o_dout_oe_n,
   input  wire [`ADCS_DATA_W-1:0] i_conv_sample,
   input  wire                    i_conv_over,
   input  wire                    i_conv_under,
   output reg                     o_mod_reset,
   output wire                    o_analog_on,
   output reg  [1:0]              o_input_select
);

   localparam [1:0] ST_CMD = 2'h0;
   localparam [1:0] ST_WR  = 2'h1;
   localparam [1:0] ST_RD  = 2'h2;
   localparam [1:0] ST_CRD = 2'h3;

   // ==========================================================
   // pin synchronisation and serial clock edges
   // ==========================================================
   wire [2:0] pins_s;
   wire       cs_n_s;
   wire       sclk_s;
   wire       din_s;
   reg        sclk_d;

   adcs_sync
   #(
      .P_W    (3),
      .P_INIT (`ADCS_PIN_INIT)
   )
   u_sync
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_d        ({i_cs_n, i_sclk, i_din}),
      .o_q        (pins_s)
   );

   assign cs_n_s = pins_s[2];
   assign sclk_s = pins_s[1];
   assign din_s  = pins_s[0];

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         sclk_d <= 1'b1;
      else
         sclk_d <= sclk_s;
   end

   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;

   // ==========================================================
   // declarations
   // ==========================================================
   reg  [1:0]                state;
   reg                       cread;
   reg  [7:0]                rx_sh;
   reg  [`ADCS_BIT_CNT_W-1:0] rx_cnt;
   reg  [`ADCS_ONES_W-1:0]   ones_cnt;
   reg  [`ADCS_DATA_W-1:0]   tx_sh;
   reg  [`ADCS_BIT_CNT_W-1:0] tx_cnt;
   reg  [`ADCS_BIT_CNT_W-1:0] tx_last;
   reg                       tx_act;
   reg                       tx_data;
   reg  [7:0]                mode;
   reg                       rdy;
   reg                       err;
   reg  [`ADCS_DATA_W-1:0]   result;
   reg  [`ADCS_DATA_W-1:0]   next_result;
   reg                       next_clamp;
   reg                       boot;
   wire                      tmr_lead;
   wire                      tmr_done;

   wire [1:0] mode_md = mode[`ADCS_MR_MD_HI:`ADCS_MR_MD_LO];

   // R7
   // R8
   // R9
   wire [7:0] status = {rdy, err, `ADCS_SR_FIXED, P_RES_ID,
                        o_input_select};

   // ==========================================================
   // serial receive
   // ==========================================================
   wire cmd_state = (state == ST_CMD) | (state == ST_CRD);
   wire rx_bit    = sclk_rise & ~cs_n_s;
   wire rx_last   = (rx_cnt == `ADCS_BYTE_LAST);
   // a leading one on the command byte parks the bit position
   wire rx_hold   = cmd_state & (rx_cnt == `ADCS_BIT_ZERO) & din_s;
   wire rx_take   = rx_bit & (cmd_state | (state == ST_WR)) & ~rx_hold;
   // R12
   wire [7:0] rx_byte = {rx_sh[6:0], din_s};

   wire [1:0] cmd_rs = rx_byte[`ADCS_CR_RS_HI:`ADCS_CR_RS_LO];
   wire cmd_rd    = rx_byte[`ADCS_CR_RW];
   wire cmd_cr    = cmd_rd & (cmd_rs == `ADCS_RS_DATA) &
                    rx_byte[`ADCS_CR_CREAD];
   wire cmd_done  = rx_take & rx_last & cmd_state;
   // leaving continuous read is only honoured while ready is low
   wire exit_ok   = (rx_byte[`ADCS_EXIT_HI:`ADCS_EXIT_LO] ==
                     `ADCS_EXIT_CMD) & ~rdy;
   wire cmd_acc   = cmd_done & ((state == ST_CMD) | exit_ok);
   // R10
   wire mode_wr   = rx_take & rx_last & (state == ST_WR);
   wire iface_rst = rx_bit & din_s & (ones_cnt == `ADCS_ONES_LAST);
   wire chan_chg  = cmd_acc & (rx_byte[1:0] != o_input_select);

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_sh  <= 8'h00;
         rx_cnt <= `ADCS_BIT_ZERO;
      end
      else if (cs_n_s | iface_rst)
         rx_cnt <= `ADCS_BIT_ZERO;
      else if (rx_take)
      begin
         rx_sh  <= rx_byte;
         rx_cnt <= rx_last ? `ADCS_BIT_ZERO : rx_cnt + `ADCS_BIT_ONE;
      end
   end

   // run of ones on the data line forces an interface reset
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         ones_cnt <= {`ADCS_ONES_W{1'b0}};
      else if (rx_bit)
         ones_cnt <= (din_s & ~iface_rst) ? ones_cnt + `ADCS_ONES_ONE :
                     {`ADCS_ONES_W{1'b0}};
   end

   // ==========================================================
   // command state machine
   // ==========================================================
   wire tx_end  = tx_act & rx_bit & (tx_cnt == tx_last);
   wire rd_done = tx_end & tx_data;

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state <= ST_CMD;
         cread <= 1'b0;
      end
      else if (iface_rst)
      begin
         state <= ST_CMD;
         cread <= 1'b0;
      end
      else if (cs_n_s)
         state <= cread ? ST_CRD : ST_CMD;
      else
      begin
         case (state)
            ST_CMD:
               if (cmd_done)
               begin
                  // R17
                  if (cmd_cr)
                  begin
                     cread <= 1'b1;
                     state <= ST_CRD;
                  end
                  else if (cmd_rd)
                     state <= ST_RD;
                  else if (cmd_rs == `ADCS_RS_MODE)
                     state <= ST_WR;
               end
            ST_WR:
               if (mode_wr)
                  state <= ST_CMD;
            ST_RD:
               if (tx_end)
                  state <= ST_CMD;
            ST_CRD:
               if (cmd_acc)
               begin
                  cread <= 1'b0;
                  state <= ST_CMD;
               end
            default:
               state <= ST_CMD;
         endcase
      end
   end

   // ==========================================================
   // serial transmit
   // ==========================================================
   wire tx_load_rd = cmd_done & (state == ST_CMD) & cmd_rd & ~cmd_cr;
   wire res_wr     = tmr_done;
   // R16
   wire tx_load_cr = (state == ST_CRD) & res_wr & ~tx_act & ~cs_n_s;

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         tx_act  <= 1'b0;
         tx_data <= 1'b0;
         tx_sh   <= `ADCS_ZERO;
         tx_cnt  <= `ADCS_BIT_ZERO;
         tx_last <= `ADCS_BIT_ZERO;
      end
      else if (cs_n_s | iface_rst)
         tx_act <= 1'b0;
      else if (tx_load_rd)
      begin
         tx_act  <= 1'b1;
         tx_cnt  <= `ADCS_BIT_ZERO;
         tx_data <= (cmd_rs == `ADCS_RS_DATA);
         tx_last <= (cmd_rs == `ADCS_RS_DATA) ? `ADCS_WORD_LAST :
                    `ADCS_BYTE_LAST;
         case (cmd_rs)
            `ADCS_RS_STATUS:
               tx_sh <= {status, {`ADCS_PAD_W{1'b0}}};
            `ADCS_RS_MODE:
               tx_sh <= {mode, {`ADCS_PAD_W{1'b0}}};
            `ADCS_RS_DATA:
               tx_sh <= result;
            default:
               tx_sh <= `ADCS_ZERO;
         endcase
      end
      else if (tx_load_cr)
      begin
         tx_act  <= 1'b1;
         tx_cnt  <= `ADCS_BIT_ZERO;
         tx_data <= 1'b1;
         tx_last <= `ADCS_WORD_LAST;
         tx_sh   <= next_result;
      end
      else if (tx_act)
      begin
         if (sclk_fall)
            tx_sh <= {tx_sh[`ADCS_DATA_W-2:0], 1'b0};
         if (rx_bit)
         begin
            if (tx_cnt == tx_last)
               tx_act <= 1'b0;
            else
               tx_cnt <= tx_cnt + `ADCS_BIT_ONE;
         end
      end
   end

   // pin drives ready between words; one cycle behind the flag
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_dout      <= 1'b1;
         o_dout_oe_n <= 1'b1;
      end
      else
      begin
         o_dout_oe_n <= cs_n_s;
         // R4
         if (!tx_act)
            o_dout <= rdy;
         else if (sclk_fall)
            o_dout <= tx_sh[`ADCS_DATA_W-1];
      end
   end

   // ==========================================================
   // mode register and channel
   // ==========================================================
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         mode           <= `ADCS_MODE_RST;
         o_input_select <= `ADCS_CH_RST;
      end
      // R11
      else if (iface_rst)
      begin
         mode           <= `ADCS_MODE_RST;
         o_input_select <= `ADCS_CH_RST;
      end
      else
      begin
         if (mode_wr)
            mode <= rx_byte;
         if (cmd_acc)
            o_input_select <= rx_byte[1:0];
      end
   end

   // ==========================================================
   // conversion sequencing
   // ==========================================================
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         boot <= 1'b1;
      else
         boot <= 1'b0;
   end

   wire mode_evt = mode_wr | iface_rst | boot;
   // R14
   wire [1:0] md_new = mode_wr ?
                       rx_byte[`ADCS_MR_MD_HI:`ADCS_MR_MD_LO] :
                       (iface_rst ? `ADCS_MD_RST : mode_md);
   // R21
   // reserved code is treated as power-down
   wire md_run = (md_new == `ADCS_MD_CONT) | (md_new == `ADCS_MD_SINGLE);
   // a channel change restarts only a running continuous stream
   wire conv_start = (mode_evt & md_run) |
                     (chan_chg & (mode_md == `ADCS_MD_CONT) & ~mode_evt);
   wire conv_stop  = mode_evt & ~md_run;

   // R13
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_mod_reset <= 1'b1;
      else
         o_mod_reset <= mode_evt | chan_chg;
   end

   // R15
   // R18
   // R19
   adcs_rate_timer
   #(
      .P_PERIOD (P_RATE_CYCLES),
      .P_LEAD   (P_LEAD_CYCLES)
   )
   u_timer
   (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_start    (conv_start),
      .i_stop     (conv_stop),
      .i_repeat   (mode_md == `ADCS_MD_CONT),
      .o_lead     (tmr_lead),
      .o_done     (tmr_done),
      .o_busy     (o_analog_on)
   );

   // ==========================================================
   // result coding and flags
   // ==========================================================
   // R22
   always @*
   begin
      next_result = `ADCS_ZERO;
      next_clamp  = 1'b0;
      if (i_conv_over)
      begin
         next_result = `ADCS_FULL;
         next_clamp  = 1'b1;
      end
      else if (i_conv_under)
         next_clamp  = 1'b1;
      else if (mode[`ADCS_MR_POL])
      begin
         // straight binary spans zero to full scale only
         if (i_conv_sample[`ADCS_DATA_W-1])
            next_clamp = 1'b1;
         else
            next_result = {i_conv_sample[`ADCS_DATA_W-2:0], 1'b0};
      end
      else
         next_result = {~i_conv_sample[`ADCS_DATA_W-1],
                        i_conv_sample[`ADCS_DATA_W-2:0]};
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         result <= `ADCS_ZERO;
      else if (res_wr)
         result <= next_result;
   end

   // new result wins over any same-cycle set of ready
   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         rdy <= 1'b1;
      // R1
      // R20
      else if (res_wr)
         rdy <= 1'b0;
      // R2
      // R3
      else if (rd_done | tmr_lead | mode_wr | conv_stop | iface_rst)
         rdy <= 1'b1;
   end

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         err <= 1'b0;
      // R5
      else if (res_wr)
         err <= next_clamp;
      // R6
      else if (conv_start)
         err <= 1'b0;
   end

endmodule
`default_nettype wire

/* File: adcs_map.vh */
// constants for the converter status and mode control block
// assumes it is included by bare name from every design file
`ifndef ADCS_MAP_VH
`define ADCS_MAP_VH

// register select values
`define ADCS_RS_STATUS   2'h0
`define ADCS_RS_MODE     2'h1
`define ADCS_RS_DATA     2'h3

// command byte fields
`define ADCS_CR_RS_HI    5
`define ADCS_CR_RS_LO    4
`define ADCS_CR_RW       3
`define ADCS_CR_CREAD    2
`define ADCS_EXIT_HI     7
`define ADCS_EXIT_LO     2
`define ADCS_EXIT_CMD    6'h0e

// mode register layout and reset
`define ADCS_MODE_RST    8'h02
`define ADCS_MR_MD_HI    7
`define ADCS_MR_MD_LO    6
`define ADCS_MR_POL      2
`define ADCS_MD_RST      2'h0
`define ADCS_MD_CONT     2'h0
`define ADCS_MD_SINGLE   2'h2
`define ADCS_CH_RST      2'h0

// status register fixed bits five to three
`define ADCS_SR_FIXED    3'h1

// widths and bit counts
`define ADCS_DATA_W      24
`define ADCS_PAD_W       16
`define ADCS_CNT_W       24
`define ADCS_BIT_CNT_W   5
`define ADCS_BIT_ZERO    5'h00
`define ADCS_BIT_ONE     5'h01
`define ADCS_BYTE_LAST   5'h07
`define ADCS_WORD_LAST   5'h17
`define ADCS_ONES_W      6
`define ADCS_ONES_ONE    6'h01
`define ADCS_ONES_LAST   6'h1f
`define ADCS_FULL        24'hffffff
`define ADCS_ZERO        24'h000000

// pin synchroniser: chip select, serial clock idle high, data low
`define ADCS_PIN_INIT    3'h6

// timing: output-rate period, lead of ready before update, clock
`define ADCS_T_ADC_US    24'h00eb28
`define ADCS_LEAD_US     24'h000064
`define ADCS_CLK_MHZ     24'h000028
`define ADCS_CNT_ONE     24'h000001

`endif

/* File: adcs_sync.v */
// two flip-flop synchroniser, one chain per bit
// assumes inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none
`include "adcs_map.vh"

module adcs_sync
#(
   parameter            P_W    = 3,
   parameter [P_W-1:0]  P_INIT = `ADCS_PIN_INIT
)
(
   input  wire           i_core_clk,
   input  wire           i_rst_n,
   input  wire [P_W-1:0] i_d,
   output wire [P_W-1:0] o_q
);

   genvar g;
   generate
      for (g = 0; g < P_W; g = g + 1)
      begin : g_bit
         reg meta;
         reg stable;
         // first stage feeds the second stage only
         always @(posedge i_core_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               meta   <= P_INIT[g];
               stable <= P_INIT[g];
            end
            else
            begin
               meta   <= i_d[g];
               stable <= meta;
            end
         end
         assign o_q[g] = stable;
      end
   endgenerate

endmodule
`default_nettype wire

/* File: adcs_rate_timer.v */
// conversion timer: first result after two periods, then one each
// assumes start and stop come from logic on i_core_clk
`timescale 1ns/1ps
`default_nettype none
`include "adcs_map.vh"

module adcs_rate_timer
#(
   parameter [`ADCS_CNT_W-1:0] P_PERIOD = `ADCS_T_ADC_US * `ADCS_CLK_MHZ,
   parameter [`ADCS_CNT_W-1:0] P_LEAD   = `ADCS_LEAD_US * `ADCS_CLK_MHZ
)
(
   input  wire i_core_clk,
   input  wire i_rst_n,
   input  wire i_start,
   input  wire i_stop,
   input  wire i_repeat,
   output reg  o_lead,
   output reg  o_done,
   output reg  o_busy
);

   localparam [`ADCS_CNT_W-1:0] L_FIRST = P_PERIOD + P_PERIOD - `ADCS_CNT_ONE;
   localparam [`ADCS_CNT_W-1:0] L_NEXT  = P_PERIOD - `ADCS_CNT_ONE;

   reg [`ADCS_CNT_W-1:0] cnt;

   always @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt    <= {`ADCS_CNT_W{1'b0}};
         o_busy <= 1'b0;
         o_lead <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_lead <= 1'b0;
         o_done <= 1'b0;
         // a restart drops any result that was due
         if (i_start)
         begin
            o_busy <= 1'b1;
            cnt    <= L_FIRST;
         end
         else if (i_stop)
            o_busy <= 1'b0;
         else if (o_busy)
         begin
            if (cnt == P_LEAD)
               o_lead <= 1'b1;
            if (cnt == {`ADCS_CNT_W{1'b0}})
            begin
               o_done <= 1'b1;
               if (i_repeat)
                  cnt <= L_NEXT;
               else
                  o_busy <= 1'b0;
            end
            else
               cnt <= cnt - `ADCS_CNT_ONE;
         end
      end
   end

endmodule
`default_nettype wire

/* File: adcs_core_chk_assertions.sv */
// checker for adcs_core: ready timing, reset pulse, channel update
// assumes a bind onto adcs_core, watching its ports only
`timescale 1ns/1ps
`default_nettype none
// ====
// port checker
module adcs_core_chk
#(
   parameter [23:0] P_RATE_CYCLES = 24'h000028,
   parameter [23:0] P_LEAD_CYCLES = 24'h000005
)
(
   input wire logic       i_core_clk,
   input wire logic       i_rst_n,
   input wire logic       o_dout,
   input wire logic       o_dout_oe_n,
   input wire logic       o_mod_reset,
   input wire logic       o_analog_on,
   input wire logic [1:0] o_input_select
);
   localparam int LD = P_LEAD_CYCLES - 2;
   logic        dq;
   logic        oq;
   logic [23:0] n_mr;
   logic [23:0] n_rs;
   // only a fall on an idle line is a result, not the end of a word
   wire         rdy_fall = oq & o_dout_oe_n & dq & ~o_dout;
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         dq   <= 1'b1;
         oq   <= 1'b1;
         n_mr <= 24'h000000;
         n_rs <= 24'h000000;
      end
      else
      begin
         dq   <= o_dout;
         oq   <= o_dout_oe_n;
         n_mr <= o_mod_reset ? 24'h000000 : n_mr + {23'h0, ~&n_mr};
         n_rs <= rdy_fall ? 24'h000001 : n_rs + {23'h0, ~&n_rs};
      end
   end
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   AST_MR_PULSE: assert property (
      $rose(o_mod_reset) |=> !o_mod_reset)
      else $error("modulator reset wider than one cycle");
   AST_MR_SEL: assert property (
      $rose(o_mod_reset) |-> !o_dout_oe_n)
      else $error("modulator reset outside a selected access");
   AST_FIRST_WAIT: assert property (
      rdy_fall |-> n_mr >= 2 * P_RATE_CYCLES)
      else $error("result sooner than two periods after restart");
   AST_NEXT_WAIT: assert property (
      rdy_fall |-> n_rs >= P_RATE_CYCLES)
      else $error("results closer than one period");
   AST_LEAD: assert property (
      rdy_fall && $past(o_dout_oe_n, LD) |-> $past(o_dout, LD))
      else $error("ready not raised ahead of the update");
   AST_POWERED: assert property (
      rdy_fall |-> $past(o_analog_on, 3))
      else $error("result while converter was off");
   AST_OFF_HOLD: assert property (
      o_dout_oe_n && $past(o_dout_oe_n) && !o_analog_on &&
      !$past(o_analog_on, 3) |-> $stable(o_dout))
      else $error("ready pin moved while powered down");
   AST_SEL_CS: assert property (
      $changed(o_input_select) |-> !o_dout_oe_n)
      else $error("channel changed without a command");
   cover property (rdy_fall);
   cover property ($fell(o_analog_on));
   cover property ($rose(o_mod_reset));
endmodule
bind adcs_core adcs_core_chk
#(
   .P_RATE_CYCLES (P_RATE_CYCLES),
   .P_LEAD_CYCLES (P_LEAD_CYCLES)
)
u_chk
(
   .i_core_clk     (i_core_clk),
   .i_rst_n        (i_rst_n),
   .o_dout         (o_dout),
   .o_dout_oe_n    (o_dout_oe_n),
   .o_mod_reset    (o_mod_reset),
   .o_analog_on    (o_analog_on),
   .o_input_select (o_input_select)
);
`default_nettype wire

/* File: adcs_host_model.sv */
// host model for the three-wire port of adcs_core
// assumes calls start just after a core clock edge; sclk idles high
`timescale 1ns/1ps
`default_nettype none
// ====
// serial host
module adcs_host_model
(
   output var logic o_cs_n,
   output var logic o_sclk,
   output var logic o_din,
   input  wire logic i_dout
);
   initial
   begin
      o_cs_n = 1'b1;
      o_sclk = 1'b1;
      o_din  = 1'b0;
   end
   // long low phase: synced read bit settles before the rise
   task automatic clk_bit(input logic b, output logic r);
      o_sclk = 1'b0;
      o_din  = b;
      #125;
      r      = i_dout;
      o_sclk = 1'b1;
      #75;
   endtask
   task automatic frame(input logic [7:0] c, input logic [7:0] w,
                        input int nw, input int nr,
                        output logic [23:0] r);
      logic b;
      r      = 24'h000000;
      o_cs_n = 1'b0;
      #100;
      for (int i = 7; i >= 0; i--)
         clk_bit(c[i], b);
      for (int i = 7; i >= 8 - nw; i--)
         clk_bit(w[i], b);
      for (int i = 0; i < nr; i++)
      begin
         clk_bit(1'b0, b);
         r = {r[22:0], b};
      end
      #100;
      o_cs_n = 1'b1;
      // no pull on the line: never leave the last bit standing
      o_din  = ~o_din;
      #200;
   endtask
endmodule
`default_nettype wire

/* File: adcs_core_tb_top.sv */
// self-checking bench for adcs_core with a serial host model
// assumes a 40 MHz core clock and a shortened conversion period
`timescale 1ns/1ps
`default_nettype none
// ====
// bench top
module adcs_core_tb_top;
   localparam logic [23:0] RATE = 24'h0007d0;
   localparam logic [23:0] LEAD = 24'h000014;
   // arbitrary value
   localparam logic        RES  = 1'b1;
   localparam logic [23:0] SMP  = 24'h123456;
   localparam logic [7:0]  IDLE = {4'h8, 1'b1, RES, 2'h0};
   logic        i_core_clk    = 1'b0;
   logic        i_rst_n       = 1'b0;
   logic [23:0] i_conv_sample = SMP;
   logic        i_conv_over   = 1'b0;
   logic        i_conv_under  = 1'b0;
   wire         cs_n;
   wire         sclk;
   wire         din;
   wire         o_dout;
   wire         o_dout_oe_n;
   wire         o_mod_reset;
   wire         o_analog_on;
   wire  [1:0]  o_input_select;
   longint      trel;
   longint      t1;
   longint      t2;
   int          miscompares = 0;
   int          checks      = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   adcs_core
   #(
      .P_RATE_CYCLES (RATE),
      .P_LEAD_CYCLES (LEAD),
      .P_RES_ID      (RES)
   )
   dut
   (
      .i_core_clk     (i_core_clk),
      .i_rst_n        (i_rst_n),
      .i_cs_n         (cs_n),
      .i_sclk         (sclk),
      .i_din          (din),
      .o_dout         (o_dout),
      .o_dout_oe_n    (o_dout_oe_n),
      .i_conv_sample  (i_conv_sample),
      .i_conv_over    (i_conv_over),
      .i_conv_under   (i_conv_under),
      .o_mod_reset    (o_mod_reset),
      .o_analog_on    (o_analog_on),
      .o_input_select (o_input_select)
   );
   adcs_host_model u_host
   (
      .o_cs_n (cs_n),
      .o_sclk (sclk),
      .o_din  (din),
      .i_dout (o_dout)
   );
   task automatic check(input string nm, input logic [23:0] e,
                        input logic [23:0] g);
      checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      if (miscompares == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic rd(input logic [7:0] c, input int n,
                     output logic [23:0] r);
      u_host.frame(c, 8'h00, 0, n, r);
   endtask
   task automatic wr(input logic [7:0] m);
      logic [23:0] r;
      u_host.frame(8'h10, m, 8, 0, r);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #2;
   endtask
   task automatic wait_rdy(output longint t);
      int n;
      for (n = 0; n < 3 * RATE; n++)
      begin
         cyc(1);
         if (o_dout === 1'b0 && o_dout_oe_n === 1'b1)
            break;
      end
      check("ready_pin", 24'h000001, {23'h0, n < 3 * RATE});
      t = $time;
   endtask
   task automatic sc_reset;
      logic [23:0] r;
      rd(8'h08, 8, r);
      check("status_reset", {16'h0, IDLE}, r);
      rd(8'h18, 8, r);
      check("mode_reset", 24'h000002, r);
   endtask
   task automatic sc_cont;
      logic [23:0] r;
      wait_rdy(t1);
      r = 24'((t1 - trel) / 25 - 2 * RATE);
      check("first_result", 24'h000001, {23'h0, r <= 24'h000008});
      rd(8'h38, 24, r);
      check("data_offset", SMP ^ 24'h800000, r);
      rd(8'h08, 8, r);
      check("status_after_read", {16'h0, IDLE}, r);
      wait_rdy(t2);
      check("result_gap", RATE, 24'((t2 - t1) / 25));
   endtask
   task automatic sc_error;
      logic [23:0] r;
      longint      t;
      i_conv_over = 1'b1;
      rd(8'h08, 8, r);
      check("status_new_result", {16'h0, IDLE & 8'h7f}, r);
      rd(8'h38, 24, r);
      wait_rdy(t);
      rd(8'h08, 8, r);
      check("status_clamped", {16'h0, IDLE & 8'h7f | 8'h40}, r);
      rd(8'h38, 24, r);
      check("data_clamped", 24'hffffff, r);
      i_conv_over = 1'b0;
      wr(8'h02);
      rd(8'h08, 8, r);
      check("status_mode_write", {16'h0, IDLE}, r);
   endtask
   task automatic sc_unipolar;
      logic [23:0] r;
      longint      t;
      wr(8'h06);
      wait_rdy(t);
      rd(8'h38, 24, r);
      check("data_straight", SMP << 1, r);
   endtask
   task automatic sc_single;
      logic [23:0] r;
      longint      t;
      wr(8'h82);
      check("single_on", 24'h000001, {23'h0, o_analog_on});
      wait_rdy(t);
      cyc(4);
      check("single_off", 24'h000000, {23'h0, o_analog_on});
      cyc(2 * RATE);
      check("single_held", 24'h000000, {23'h0, o_dout});
      rd(8'h08, 8, r);
      check("single_status", {16'h0, IDLE & 8'h7f}, r);
      rd(8'h38, 24, r);
      check("single_data", SMP ^ 24'h800000, r);
      check("ready_after_read", 24'h000001, {23'h0, o_dout});
   endtask
   task automatic sc_power;
      logic [23:0] r;
      logic [7:0]  m [2] = '{8'h42, 8'hc2};
      foreach (m[i])
      begin
         wr(m[i]);
         rd(8'h08, 8, r);
         check("status_off", {16'h0, IDLE}, r);
         check("power_off", 24'h000000, {23'h0, o_analog_on});
      end
      rd(8'h18, 8, r);
      check("mode_readback", 24'h0000c2, r);
      rd(8'h0b, 8, r);
      rd(8'h0b, 8, r);
      check("status_channel", {16'h0, IDLE | 8'h03}, r);
      check("channel_pin", 24'h000003, {22'h0, o_input_select});
   endtask
   initial
   begin
      repeat (4) @(posedge i_core_clk);
      #2;
      i_rst_n = 1'b1;
      trel    = $time;
      sc_reset();
      sc_cont();
      sc_error();
      sc_unipolar();
      sc_single();
      sc_power();
      complete_run();
   end
   initial
   begin
      #2000000;
      miscompares++;
      complete_run();
   end
endmodule
`default_nettype wire
